/* design/blsb_pkg.sv */
package blsb_pkg;

  // ************************************************************
  // Register map, byte addresses on the APB
  // ************************************************************
  localparam logic [7:0] ADDR_DEST   = 8'h00;
  localparam logic [7:0] ADDR_SRC    = 8'h04;
  localparam logic [7:0] ADDR_IMM    = 8'h08;
  localparam logic [7:0] ADDR_FLAGS  = 8'h0C;
  localparam logic [7:0] ADDR_CMD    = 8'h10;
  localparam logic [7:0] ADDR_RESULT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // ************************************************************
  // Field layout
  // ************************************************************
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_OP_W      = 5;
  localparam int CMD_IMM_BIT   = 8;
  localparam int CMD_REGPOS_BIT = 9;
  localparam int FLAG_C        = 0;
  localparam int FLAG_V        = 1;
  localparam int FLAG_Z        = 2;
  localparam int FLAG_N        = 3;
  localparam int FLAG_W        = 4;
  localparam int BYTE_W        = 8;
  localparam int BYTE_MSB      = 7;
  localparam int POS_W         = 3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [3:0]  RST_FLAGS = 4'h0;
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;

  // ************************************************************
  // Operations
  // ************************************************************
  typedef enum logic [4:0] {
    OP_AND, OP_OR, OP_XOR, OP_NOT,
    OP_ARITH_SHIFT_LEFT, OP_ARITH_SHIFT_RIGHT,
    OP_LOGIC_SHIFT_LEFT, OP_LOGIC_SHIFT_RIGHT,
    OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
    OP_ROTATE_CARRY_LEFT, OP_ROTATE_CARRY_RIGHT,
    OP_BIT_FORCE_ONE, OP_BIT_FORCE_ZERO, OP_BIT_TOGGLE, OP_BIT_PROBE,
    OP_CARRY_AND_BIT, OP_CARRY_AND_INVERTED_BIT,
    OP_CARRY_OR_BIT, OP_CARRY_OR_INVERTED_BIT,
    OP_ILLEGAL
  } blsb_op_e;

  localparam logic [4:0] OP_COUNT = 5'h14;

  typedef struct packed {
    logic [7:0]  dest;
    logic [7:0]  src;
    logic [7:0]  imm;
    logic [3:0]  flags;
    logic [7:0]  result;
    logic        err;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } blsb_state_s;

endpackage : blsb_pkg

/* design/blsb_alu.sv */
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module blsb_alu (
  input  wire logic        SYS_CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);

  blsb_pkg::blsb_state_s st_reg;
  blsb_pkg::blsb_state_s st_next;

  logic                 acc;
  logic                 exec;
  logic                 use_imm;
  logic                 reg_pos;
  logic [4:0]           op_code;
  blsb_pkg::blsb_op_e   cur_op;
  logic [7:0]           a_val;
  logic [7:0]           src_val;
  logic [2:0]           pos;
  logic                 bit_v;
  logic                 cy;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr == blsb_pkg::ADDR_DEST)   || (addr == blsb_pkg::ADDR_SRC)    ||
                (addr == blsb_pkg::ADDR_IMM)    || (addr == blsb_pkg::ADDR_FLAGS)  ||
                (addr == blsb_pkg::ADDR_CMD)    || (addr == blsb_pkg::ADDR_RESULT) ||
                (addr == blsb_pkg::ADDR_STATUS);
  endfunction : is_mapped

  function automatic blsb_pkg::blsb_op_e to_op(input logic [4:0] code);
    if (code < blsb_pkg::OP_COUNT) begin
      to_op = blsb_pkg::blsb_op_e'(code);
    end else begin
      to_op = blsb_pkg::OP_ILLEGAL;
    end
  endfunction : to_op

  function automatic logic [3:0] nz_flags(input logic [7:0] r, input logic c, input logic v);
    logic [3:0] f;
    f = blsb_pkg::RST_FLAGS;
    f[blsb_pkg::FLAG_N] = r[blsb_pkg::BYTE_MSB];
    f[blsb_pkg::FLAG_Z] = (r == blsb_pkg::RST_BYTE);
    f[blsb_pkg::FLAG_V] = v;
    f[blsb_pkg::FLAG_C] = c;
    nz_flags = f;
  endfunction : nz_flags

  // ************************************************************
  // Operand selection
  // ************************************************************
  assign acc     = PSEL && PENABLE && st_reg.pready;
  assign exec    = acc && PWRITE && (PADDR == blsb_pkg::ADDR_CMD);
  assign op_code = PWDATA[blsb_pkg::CMD_OP_LSB +: blsb_pkg::CMD_OP_W];
  assign cur_op  = to_op(op_code);
  assign use_imm = PWDATA[blsb_pkg::CMD_IMM_BIT];
  assign reg_pos = PWDATA[blsb_pkg::CMD_REGPOS_BIT];
  assign a_val   = st_reg.dest;
  assign src_val = use_imm ? st_reg.imm : st_reg.src;
  assign pos     = reg_pos ? st_reg.src[blsb_pkg::POS_W-1:0]
                           : st_reg.imm[blsb_pkg::POS_W-1:0];
  assign bit_v   = a_val[pos];
  assign cy      = st_reg.flags[blsb_pkg::FLAG_C];

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [7:0] res;
    logic [3:0] fl;
    logic       wr_back;
    res     = a_val;
    fl      = st_reg.flags;
    wr_back = 1'b0;
    st_next = st_reg;

    // Registered answer, prepared in the setup phase, adds no wait state and keeps PRDATA glitch-free
    st_next.pready  = PSEL && !PENABLE;
    st_next.pslverr = PSEL && !PENABLE && !is_mapped(PADDR);
    if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        blsb_pkg::ADDR_DEST:   st_next.prdata = {24'h000000, st_reg.dest};
        blsb_pkg::ADDR_SRC:    st_next.prdata = {24'h000000, st_reg.src};
        blsb_pkg::ADDR_IMM:    st_next.prdata = {24'h000000, st_reg.imm};
        blsb_pkg::ADDR_FLAGS:  st_next.prdata = {28'h0000000, st_reg.flags};
        blsb_pkg::ADDR_RESULT: st_next.prdata = {24'h000000, st_reg.result};
        blsb_pkg::ADDR_STATUS: st_next.prdata = {31'h00000000, st_reg.err};
        default:               st_next.prdata = blsb_pkg::RST_WORD;
      endcase
    end

    if (acc && PWRITE) begin
      case (PADDR)
        blsb_pkg::ADDR_DEST:  st_next.dest  = PWDATA[blsb_pkg::BYTE_W-1:0];
        blsb_pkg::ADDR_SRC:   st_next.src   = PWDATA[blsb_pkg::BYTE_W-1:0];
        blsb_pkg::ADDR_IMM:   st_next.imm   = PWDATA[blsb_pkg::BYTE_W-1:0];
        blsb_pkg::ADDR_FLAGS: st_next.flags = PWDATA[blsb_pkg::FLAG_W-1:0];
        default: ;
      endcase
    end

    if (exec) begin
      st_next.err = 1'b0;
      case (cur_op)
        blsb_pkg::OP_AND: begin
          res = a_val & src_val;
          fl  = nz_flags(res, cy, 1'b0);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_OR: begin
          res = a_val | src_val;
          fl  = nz_flags(res, cy, 1'b0);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_XOR: begin
          res = a_val ^ src_val;
          fl  = nz_flags(res, cy, 1'b0);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_NOT: begin
          res = ~a_val;
          fl  = nz_flags(res, cy, 1'b0);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_ARITH_SHIFT_LEFT: begin
          res = {a_val[6:0], 1'b0};
          // Overflow when the sign changes
          fl  = nz_flags(res, a_val[7], a_val[7] ^ a_val[6]);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_ARITH_SHIFT_RIGHT: begin
          res = {a_val[7], a_val[7:1]};
          fl  = nz_flags(res, a_val[0], 1'b0);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_LOGIC_SHIFT_LEFT: begin
          res = {a_val[6:0], 1'b0};
          fl  = nz_flags(res, a_val[7], 1'b0);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_LOGIC_SHIFT_RIGHT: begin
          res = {1'b0, a_val[7:1]};
          fl  = nz_flags(res, a_val[0], 1'b0);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_ROTATE_LEFT: begin
          res = {a_val[6:0], a_val[7]};
          fl  = nz_flags(res, a_val[7], 1'b0);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_ROTATE_RIGHT: begin
          res = {a_val[0], a_val[7:1]};
          fl  = nz_flags(res, a_val[0], 1'b0);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_ROTATE_CARRY_LEFT: begin
          res = {a_val[6:0], cy};
          fl  = nz_flags(res, a_val[7], 1'b0);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_ROTATE_CARRY_RIGHT: begin
          res = {cy, a_val[7:1]};
          fl  = nz_flags(res, a_val[0], 1'b0);
          wr_back = 1'b1;
        end
        blsb_pkg::OP_BIT_FORCE_ONE: begin
          res[pos] = 1'b1;
          wr_back  = 1'b1;
        end
        blsb_pkg::OP_BIT_FORCE_ZERO: begin
          res[pos] = 1'b0;
          wr_back  = 1'b1;
        end
        blsb_pkg::OP_BIT_TOGGLE: begin
          res[pos] = ~bit_v;
          wr_back  = 1'b1;
        end
        blsb_pkg::OP_BIT_PROBE: begin
          fl[blsb_pkg::FLAG_Z] = ~bit_v;
        end
        blsb_pkg::OP_CARRY_AND_BIT: begin
          fl[blsb_pkg::FLAG_C] = cy & bit_v;
        end
        blsb_pkg::OP_CARRY_OR_BIT: begin
          fl[blsb_pkg::FLAG_C] = cy | bit_v;
        end
        blsb_pkg::OP_CARRY_AND_INVERTED_BIT: begin
          if (reg_pos) begin
            st_next.err = 1'b1;
          end else begin
            fl[blsb_pkg::FLAG_C] = cy & ~bit_v;
          end
        end
        blsb_pkg::OP_CARRY_OR_INVERTED_BIT: begin
          if (reg_pos) begin
            st_next.err = 1'b1;
          end else begin
            fl[blsb_pkg::FLAG_C] = cy | ~bit_v;
          end
        end
        default: begin
          st_next.err = 1'b1;
        end
      endcase
      st_next.flags = fl;
      if (wr_back) begin
        st_next.dest   = res;
        st_next.result = res;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_reg <= '{dest: blsb_pkg::RST_BYTE, src: blsb_pkg::RST_BYTE,
                  imm: blsb_pkg::RST_BYTE, flags: blsb_pkg::RST_FLAGS,
                  result: blsb_pkg::RST_BYTE, err: 1'b0,
                  prdata: blsb_pkg::RST_WORD, pready: 1'b0, pslverr: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign PRDATA  = st_reg.prdata;
  assign PREADY  = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  a_and_result: assert property (exec && cur_op == blsb_pkg::OP_AND |=>
    st_reg.dest == ($past(a_val) & $past(src_val))) else $error("AND result wrong");
  a_or_result: assert property (exec && cur_op == blsb_pkg::OP_OR |=>
    st_reg.dest == ($past(a_val) | $past(src_val))) else $error("OR result wrong");
  a_xor_result: assert property (exec && cur_op == blsb_pkg::OP_XOR |=>
    st_reg.result == ($past(a_val) ^ $past(src_val))) else $error("XOR result wrong");
  a_not_result: assert property (exec && cur_op == blsb_pkg::OP_NOT |=>
    st_reg.dest == ~$past(a_val)) else $error("Complement wrong");
  a_sign_kept: assert property (exec && cur_op == blsb_pkg::OP_ARITH_SHIFT_RIGHT |=>
    st_reg.dest[7:6] == {2{$past(a_val[7])}}) else $error("Sign bit lost");
  a_rotc_loop: assert property (exec && cur_op == blsb_pkg::OP_ROTATE_CARRY_LEFT |=>
    {st_reg.flags[blsb_pkg::FLAG_C], st_reg.dest} == {$past(a_val), $past(cy)})
    else $error("Carry rotate loop broken");
  a_shift_carry: assert property (exec && cur_op == blsb_pkg::OP_LOGIC_SHIFT_RIGHT |=>
    st_reg.flags[blsb_pkg::FLAG_C] == $past(a_val[0]) && st_reg.dest[7] == 1'b0)
    else $error("Shifted-out bit not in carry");
  a_force_one: assert property (exec && cur_op == blsb_pkg::OP_BIT_FORCE_ONE |=>
    st_reg.dest == ($past(a_val) | (8'h01 << $past(pos)))) else $error("Bit set wrong");
  a_probe_zflag: assert property (exec && cur_op == blsb_pkg::OP_BIT_PROBE |=>
    st_reg.flags[blsb_pkg::FLAG_Z] == !$past(bit_v) && $stable(st_reg.dest))
    else $error("Bit probe wrong");
  a_inv_regpos: assert property (exec && reg_pos &&
    (cur_op == blsb_pkg::OP_CARRY_OR_INVERTED_BIT || cur_op == blsb_pkg::OP_CARRY_AND_INVERTED_BIT)
    |=> st_reg.err && $stable(st_reg.flags)) else $error("Register position accepted");
  a_logic_flags: assert property (exec && cur_op == blsb_pkg::OP_XOR |=>
    !st_reg.flags[blsb_pkg::FLAG_V] && st_reg.flags[blsb_pkg::FLAG_C] == $past(cy))
    else $error("Logic flags wrong");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("Ready held over");

  // ************************************************************
  // Shift, rotate and bit checks
  // ************************************************************
  a_lsl_fill: assert property (
    exec && cur_op == blsb_pkg::OP_LOGIC_SHIFT_LEFT |=>
    st_reg.dest == {$past(a_val[6:0]), 1'b0} &&
    st_reg.flags[blsb_pkg::FLAG_C] == $past(a_val[7]))
    else $error("Logic shift left wrong");
  a_asl_flags: assert property (
    exec && cur_op == blsb_pkg::OP_ARITH_SHIFT_LEFT |=>
    st_reg.flags[blsb_pkg::FLAG_C] == $past(a_val[7]) &&
    st_reg.flags[blsb_pkg::FLAG_V] == ($past(a_val[7]) ^ $past(a_val[6])))
    else $error("Arithmetic shift left flags wrong");
  a_rol_wrap: assert property (
    exec && cur_op == blsb_pkg::OP_ROTATE_LEFT |=>
    st_reg.dest == {$past(a_val[6:0]), $past(a_val[7])})
    else $error("Rotate left wrong");
  a_ror_wrap: assert property (
    exec && cur_op == blsb_pkg::OP_ROTATE_RIGHT |=>
    st_reg.dest == {$past(a_val[0]), $past(a_val[7:1])} &&
    st_reg.flags[blsb_pkg::FLAG_C] == $past(a_val[0]))
    else $error("Rotate right wrong");
  a_rcr_loop: assert property (
    exec && cur_op == blsb_pkg::OP_ROTATE_CARRY_RIGHT |=>
    {st_reg.dest, st_reg.flags[blsb_pkg::FLAG_C]} == {$past(cy), $past(a_val)})
    else $error("Carry rotate right loop broken");
  a_force_zero: assert property (
    exec && cur_op == blsb_pkg::OP_BIT_FORCE_ZERO |=>
    st_reg.dest == ($past(a_val) & ~(8'h01 << $past(pos))))
    else $error("Bit clear wrong");
  a_toggle_bit: assert property (
    exec && cur_op == blsb_pkg::OP_BIT_TOGGLE |=>
    st_reg.dest == ($past(a_val) ^ (8'h01 << $past(pos))) && st_reg.result == st_reg.dest)
    else $error("Bit toggle wrong");
  a_pos_register: assert property (
    exec && cur_op == blsb_pkg::OP_BIT_FORCE_ONE && reg_pos |=>
    st_reg.dest[$past(st_reg.src[blsb_pkg::POS_W-1:0])] == 1'b1)
    else $error("Register bit position ignored");
  a_pos_immediate: assert property (
    exec && cur_op == blsb_pkg::OP_BIT_FORCE_ZERO && !reg_pos |=>
    st_reg.dest[$past(st_reg.imm[blsb_pkg::POS_W-1:0])] == 1'b0)
    else $error("Immediate bit position ignored");
  a_bit_flags_kept: assert property (
    exec && (cur_op == blsb_pkg::OP_BIT_FORCE_ONE || cur_op == blsb_pkg::OP_BIT_TOGGLE) |=>
    $stable(st_reg.flags))
    else $error("Bit write touched flags");
  a_probe_keeps: assert property (
    exec && cur_op == blsb_pkg::OP_BIT_PROBE |=>
    $stable(st_reg.result) && st_reg.flags[blsb_pkg::FLAG_C] == $past(cy))
    else $error("Bit probe changed more than Z");

  // ************************************************************
  // Carry, flag and bus checks
  // ************************************************************
  a_carry_and: assert property (
    exec && cur_op == blsb_pkg::OP_CARRY_AND_BIT |=>
    st_reg.flags[blsb_pkg::FLAG_C] == ($past(cy) & $past(a_val[pos])) && $stable(st_reg.dest))
    else $error("Carry AND bit wrong");
  a_carry_and_inv: assert property (
    exec && cur_op == blsb_pkg::OP_CARRY_AND_INVERTED_BIT && !reg_pos |=>
    st_reg.flags[blsb_pkg::FLAG_C] == ($past(cy) & ~$past(a_val[pos])))
    else $error("Carry AND inverted bit wrong");
  a_carry_or: assert property (
    exec && cur_op == blsb_pkg::OP_CARRY_OR_BIT |=>
    st_reg.flags[blsb_pkg::FLAG_C] == ($past(cy) | $past(a_val[pos])) && $stable(st_reg.dest))
    else $error("Carry OR bit wrong");
  a_carry_or_inv: assert property (
    exec && cur_op == blsb_pkg::OP_CARRY_OR_INVERTED_BIT && !reg_pos |=>
    st_reg.flags[blsb_pkg::FLAG_C] == ($past(cy) | ~$past(a_val[pos])))
    else $error("Carry OR inverted bit wrong");
  a_and_nz: assert property (
    exec && cur_op == blsb_pkg::OP_AND |=>
    st_reg.flags[blsb_pkg::FLAG_N] == st_reg.dest[blsb_pkg::BYTE_MSB] &&
    st_reg.flags[blsb_pkg::FLAG_Z] == (st_reg.dest == blsb_pkg::RST_BYTE))
    else $error("Logic result flags wrong");
  a_illegal_err: assert property (
    exec && cur_op == blsb_pkg::OP_ILLEGAL |=>
    st_reg.err && $stable(st_reg.dest) && $stable(st_reg.flags))
    else $error("Illegal operation not flagged");
  a_ready_setup: assert property (
    PSEL && !PENABLE |=> PREADY)
    else $error("No ready after setup");
  a_unmapped_err: assert property (
    PSEL && !PENABLE && !is_mapped(PADDR) |=> PSLVERR)
    else $error("Unmapped address accepted");
  a_idle_hold: assert property (
    !acc |=> $stable(st_reg.dest) && $stable(st_reg.flags) && $stable(st_reg.result))
    else $error("State changed without a bus access");

  c_rotc: cover property (exec && cur_op == blsb_pkg::OP_ROTATE_CARRY_RIGHT && cy);
  c_toggle: cover property (exec && cur_op == blsb_pkg::OP_BIT_TOGGLE && reg_pos);
  c_bad_addr: cover property (PREADY && PSLVERR);
  c_cor_inv: cover property (exec && cur_op == blsb_pkg::OP_CARRY_OR_INVERTED_BIT && !reg_pos);
  c_illegal: cover property (exec && cur_op == blsb_pkg::OP_ILLEGAL);

endmodule : blsb_alu

/* test/test_byte_logic_shift_bit_alu.sv */
`timescale 1ns/10ps
module test_byte_logic_shift_bit_alu;
  logic        SYS_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rng;
  logic [33:0] notes[$];
  logic [7:0]  m_dest, m_src, m_imm, m_res;
  logic [3:0]  m_flags;
  logic        m_err;
  int          fails, checks_done;

  blsb_alu dut_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  task automatic print_verdict();
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // ************************************************************
  // APB master; expectation queued before the request goes out
  // ************************************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] ex, input logic ex_err);
    notes.push_back({~wr, ex_err, ex});
    @(posedge SYS_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= wd;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge SYS_CLK);
    end while (PREADY !== 1'b1);
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  // Monitor: every completed access retires the oldest note
  always @(posedge SYS_CLK) begin
    logic [33:0] nt;
    if (PSEL === 1'b1 && PENABLE === 1'b1 && PREADY === 1'b1) begin
      checks_done++;
      nt = (notes.size() > 0) ? notes.pop_front() : 34'h3FFFFFFFF;
      if (PSLVERR !== nt[32] || (nt[33] && PRDATA !== nt[31:0])) begin
        fails++;
        $display("[FAIL] t=%0t exp=%h got=%h err_exp=%h err_got=%h", $time, nt[31:0],
                 PRDATA, nt[32], PSLVERR);
      end
    end
  end

  // ************************************************************
  // Reference behaviour of one command
  // ************************************************************
  task automatic model(input logic [4:0] op, input logic b8, input logic b9);
    logic [7:0] d, o, r;
    logic [2:0] p;
    logic       c, co, v;
    d = m_dest;
    o = b8 ? m_imm : m_src;
    p = b9 ? m_src[2:0] : m_imm[2:0];
    c = m_flags[blsb_pkg::FLAG_C];
    r = d;
    co = c;
    v = 1'b0;
    case (op)
      5'h00: r = d & o;
      5'h01: r = d | o;
      5'h02: r = d ^ o;
      5'h03: r = ~d;
      5'h04: {co, r, v} = {d, 1'b0, d[7] ^ d[6]};
      5'h05: {r, co} = {d[7], d};
      5'h06: {co, r} = {d, 1'b0};
      5'h07: {r, co} = {1'b0, d};
      5'h08: {co, r} = {d, d[7]};
      5'h09: {r, co} = {d[0], d};
      5'h0A: {co, r} = {d, c};
      5'h0B: {r, co} = {c, d};
      5'h0C: r[p] = 1'b1;
      5'h0D: r[p] = 1'b0;
      5'h0E: r[p] = ~d[p];
      5'h10: co = c & d[p];
      5'h11: co = c & ~d[p];
      5'h12: co = c | d[p];
      5'h13: co = c | ~d[p];
      default: r = d;
    endcase
    m_err = (op > 5'h13) || ((op == 5'h11 || op == 5'h13) && b9);
    if (!m_err) begin
      if (op <= 5'h0B) m_flags = {r[7], r == 8'h00, v, co};
      else if (op == 5'h0F) m_flags[blsb_pkg::FLAG_Z] = ~d[p];
      else if (op >= 5'h10) m_flags[blsb_pkg::FLAG_C] = co;
      if (op <= 5'h0E) begin
        m_dest = r;
        m_res = r;
      end
    end
  endtask : model

  task automatic run_op(input logic [4:0] op, input logic b8, input logic b9);
    logic [31:0] wd, ws, wi, wf;
    wd = xs();
    ws = xs();
    wi = xs();
    wf = xs();
    apb(1'b1, blsb_pkg::ADDR_DEST, wd, 32'h0, 1'b0);
    apb(1'b1, blsb_pkg::ADDR_SRC, ws, 32'h0, 1'b0);
    apb(1'b1, blsb_pkg::ADDR_IMM, wi, 32'h0, 1'b0);
    apb(1'b1, blsb_pkg::ADDR_FLAGS, wf, 32'h0, 1'b0);
    m_dest = wd[7:0];
    m_src = ws[7:0];
    m_imm = wi[7:0];
    m_flags = wf[3:0];
    apb(1'b1, blsb_pkg::ADDR_CMD, {22'h0, b9, b8, 3'h0, op}, 32'h0, 1'b0);
    model(op, b8, b9);
    apb(1'b0, blsb_pkg::ADDR_DEST, 32'h0, {24'h0, m_dest}, 1'b0);
    apb(1'b0, blsb_pkg::ADDR_FLAGS, 32'h0, {28'h0, m_flags}, 1'b0);
    apb(1'b0, blsb_pkg::ADDR_RESULT, 32'h0, {24'h0, m_res}, 1'b0);
    apb(1'b0, blsb_pkg::ADDR_STATUS, 32'h0, {31'h0, m_err}, 1'b0);
  endtask : run_op

  // ************************************************************
  // Stimulus
  // ************************************************************
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  initial begin
    repeat (20000) @(posedge SYS_CLK);
    fails++;
    print_verdict();
  end

  initial begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    rng = 32'h000053B9;
    fails = 0;
    checks_done = 0;
    m_res = 8'h00;
    repeat (5) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, 32'h0, 1'b0);
    end
    apb(1'b0, 8'h1C, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h40, 32'hFFFFFFFF, 32'h0, 1'b1);
    apb(1'b1, blsb_pkg::ADDR_RESULT, 32'hFFFFFFFF, 32'h0, 1'b0);
    apb(1'b0, blsb_pkg::ADDR_RESULT, 32'h0, 32'h0, 1'b0);
    for (int i = 0; i < 100; i++) begin
      run_op((i < 40) ? 5'(i % 20) : 5'(xs() % 32), rng[8], rng[9]);
    end
    RST_N <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    m_res = 8'h00;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, 32'h0, 1'b0);
    end
    run_op(5'h11, 1'b0, 1'b1);
    run_op(5'h13, 1'b1, 1'b1);
    run_op(5'h15, 1'b0, 1'b0);
    run_op(5'h0F, 1'b0, 1'b1);
    repeat (3) @(posedge SYS_CLK);
    print_verdict();
  end
endmodule : test_byte_logic_shift_bit_alu
